// ### hdl/dul_display_link.sv
// What this block does
// - Idle means refresh only, receivers listening
// - Blinking is part of ordinary refresh
// - Command word then exactly counted data words
// - Command word field layout is fixed
// - Data word field layout is fixed
// - Payload: four-bit code, twelve-bit value
// - Both send requests and receive commands
// - Accept, interpret and act on key codes
// - Buffer keys, echo on scratch-pad line
// - Enter is not echoed, authorizes action
// - Blink, normal and bright intensities
// - Merge skeleton with variables, accept self-test
// - Display-calling entry starts request to computers
// - Eleven-bit check code generated and verified
// - Manchester serial words at one megahertz
// - Interrupt only when unit address matches
`timescale 1ns/1ps
module dul_display_link #(
	parameter int PAD_DEPTH      = 8,
	parameter int FIFO_DEPTH     = 8,
	parameter int BLINK_HALF_CYC = dul_pkg::BLINK_HALF_CYC
) (
	input  logic                        clk,
	input  logic                        reset,
	input  logic                        link_rx_line,
	output logic                        link_tx_line,
	input  logic [4:0]                  unit_address,
	input  logic                        key_valid,
	input  logic [4:0]                  key_code,
	input  logic                        selftest_valid,
	input  logic [7:0]                  selftest_code,
	input  logic                        selftest_fail,
	output logic                        elem_valid,
	input  logic                        elem_ready,
	output dul_pkg::dul_elem_type       elem,
	output logic                        elem_visible,
	output logic [PAD_DEPTH*5-1:0]      pad_codes,
	output logic [$clog2(PAD_DEPTH+1)-1:0] pad_count,
	output logic                        msg_irq,
	output logic                        msg_error,
	output logic                        blink_on,
	output logic                        quiescent,
	output logic [7:0]                  selftest_status
);
	localparam int         PCW    = $clog2(PAD_DEPTH + 1);
	localparam logic [4:0] C_S1   = 5'(dul_pkg::SAMPLE1_CYC);
	localparam logic [4:0] C_S2   = 5'(dul_pkg::SAMPLE2_CYC);
	localparam logic [4:0] C_LAST = 5'(dul_pkg::BIT_CYC - 1);
	localparam logic [5:0] C_WEND = 6'(dul_pkg::WORD_BITS - 1);
	localparam logic [31:0] C_BLINK = 32'(BLINK_HALF_CYC - 1);

	// ==========================================================
	// State
	typedef enum logic [1:0] {RX_IDLE, RX_BIT, RX_WAIT_LOW} dul_rx_state_type;
	typedef enum logic [1:0] {M_IDLE, M_COLLECT, M_DRAIN} dul_msg_state_type;
	typedef enum logic [1:0] {T_IDLE, T_CMD, T_DATA} dul_tx_state_type;
	typedef struct packed {
		logic                        s1;
		logic                        s2;
		logic                        s3;
		dul_rx_state_type            rx_st;
		logic [4:0]                  cyc;
		logic [5:0]                  bidx;
		logic                        half1;
		logic                        code_err;
		logic [37:0]                 shreg;
		logic                        word_done;
		dul_msg_state_type           mstate;
		logic                        foreign;
		logic [4:0]                  remaining;
		logic [4:0]                  nwords;
		logic [4:0]                  didx;
		logic                        skel;
		dul_pkg::dul_elem_type [30:0] store;
		logic                        irq;
		logic                        err;
		logic [PAD_DEPTH-1:0][4:0]   pad;
		logic [PCW-1:0]              pcount;
		dul_tx_state_type            tst;
		logic [PCW-1:0]              tidx;
		logic                        fmt;
		logic [31:0]                 bcnt;
		logic                        blink;
		logic [7:0]                  selftest;
	} dul_state_type;
	dul_state_type         st_reg;
	dul_state_type         st_next;
	dul_pkg::dul_cmd_type  w_cmd;
	dul_pkg::dul_data_type w_data;
	logic                  w_ok;
	logic                  rx_hi;
	logic                  rx_lo;
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  tx_valid;
	logic                  tx_ready;
	logic [26:0]           tx_body;
	logic [1:0]            w_int;
	assign w_cmd  = dul_pkg::dul_cmd_type'(st_reg.shreg);
	assign w_data = dul_pkg::dul_data_type'(st_reg.shreg);
	assign w_ok   = !st_reg.code_err
		&& (w_cmd.word_check_code == dul_pkg::dul_check_code(st_reg.shreg[37:11]));
	assign w_int  = (w_data.ctrl[1:0] == 2'h3) ? dul_pkg::INT_NORMAL : w_data.ctrl[1:0];
	// Only agreeing late stages decide a level
	assign rx_hi  = st_reg.s2 && st_reg.s3;
	assign rx_lo  = !st_reg.s2 && !st_reg.s3;
	assign fifo_in_valid = st_reg.mstate == M_DRAIN;
	assign tx_valid      = st_reg.tst != T_IDLE;

	// ==========================================================
	// Outgoing word assembly
	always_comb begin
		if (st_reg.tst == T_CMD) begin
			tx_body = {dul_pkg::SYNC_CMD,
				st_reg.fmt ? dul_pkg::MSGC_FORMAT_REQ : dul_pkg::MSGC_KEY_DATA,
				unit_address, 1'b0, 9'h000, 5'(st_reg.pcount)};
		end else begin
			tx_body = {dul_pkg::SYNC_DATA, 8'h00, 11'h000, st_reg.pad[st_reg.tidx]};
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.word_done = 1'b0;
		st_next.irq = 1'b0;
		st_next.err = 1'b0;
		// Receiver always listens, even while a reply is sent
		st_next.s1 = link_rx_line;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		case (st_reg.rx_st)
			RX_IDLE: begin
				if (rx_hi) begin
					st_next.rx_st    = RX_BIT;
					st_next.cyc      = '0;
					st_next.bidx     = '0;
					st_next.code_err = 1'b0;
				end
			end
			RX_BIT: begin
				st_next.cyc = st_reg.cyc + 5'h01;
				if (st_reg.cyc == C_S1) begin
					st_next.half1 = st_reg.s3;
				end
				if (st_reg.cyc == C_S2) begin
					st_next.shreg = {st_reg.shreg[36:0], st_reg.half1};
					if (st_reg.s3 == st_reg.half1) begin
						st_next.code_err = 1'b1;
					end
				end
				if (st_reg.cyc == C_LAST) begin
					st_next.cyc  = '0;
					st_next.bidx = st_reg.bidx + 6'h01;
					if (st_reg.bidx == C_WEND) begin
						st_next.word_done = 1'b1;
						st_next.rx_st     = RX_WAIT_LOW;
					end
				end
			end
			RX_WAIT_LOW: begin
				if (rx_lo) begin
					st_next.rx_st = RX_IDLE;
				end
			end
			default: st_next.rx_st = RX_IDLE;
		endcase
		// Committed message goes out only once whole and counted
		if (fifo_in_valid && fifo_in_ready) begin
			st_next.didx = st_reg.didx + 5'h01;
			if (st_reg.didx == st_reg.nwords - 5'h01) begin
				st_next.mstate = M_IDLE;
			end
		end
		if (st_reg.word_done) begin
			if (st_reg.mstate == M_DRAIN) begin
				// No room to take a word while the last message drains
				st_next.err = 1'b1;
			end else if (!w_ok || (w_cmd.sync != dul_pkg::SYNC_CMD
				&& w_cmd.sync != dul_pkg::SYNC_DATA)) begin
				st_next.err    = 1'b1;
				st_next.mstate = M_IDLE;
			end else if (w_cmd.sync == dul_pkg::SYNC_CMD) begin
				st_next.err       = st_reg.mstate == M_COLLECT;
				st_next.foreign   = w_cmd.unit_addr != unit_address;
				st_next.mstate    = M_IDLE;
				st_next.remaining = w_cmd.count;
				st_next.nwords    = w_cmd.count;
				st_next.skel      = w_cmd.memory_area_flag;
				if (!st_next.foreign) begin
					st_next.irq = 1'b1;
					if (w_cmd.count != 5'h00) begin
						st_next.mstate = M_COLLECT;
					end
				end
			end else if (st_reg.mstate == M_COLLECT) begin
				st_next.store[st_reg.nwords - st_reg.remaining] = {st_reg.skel, w_int,
					w_data.payload[15:12], w_data.payload[11:0]};
				st_next.remaining = st_reg.remaining - 5'h01;
				if (st_reg.remaining == 5'h01) begin
					st_next.mstate = M_DRAIN;
					st_next.didx   = '0;
				end
			end else begin
				// Surplus data word after our own message
				st_next.err = !st_reg.foreign;
			end
		end
		// Keys are ignored until the last request word is handed to the transmitter
		if (st_reg.tst == T_IDLE && key_valid) begin
			if (key_code == dul_pkg::KEY_ENTER) begin
				if (st_reg.pcount != '0) begin
					st_next.tst = T_CMD;
					st_next.fmt = st_reg.pad[0] == dul_pkg::KEY_CRIT_FMT
						|| st_reg.pad[0] == dul_pkg::KEY_OTHER_FMT;
				end
			end else if (key_code == dul_pkg::KEY_CLEAR) begin
				st_next.pcount = '0;
			end else if (key_code <= dul_pkg::KEY_LAST
				&& st_reg.pcount != PCW'(PAD_DEPTH)) begin
				st_next.pad[st_reg.pcount] = key_code;
				st_next.pcount = st_reg.pcount + PCW'(1);
			end
		end
		if (tx_valid && tx_ready) begin
			case (st_reg.tst)
				T_CMD: begin
					st_next.tst  = T_DATA;
					st_next.tidx = '0;
				end
				T_DATA: begin
					st_next.tidx = st_reg.tidx + PCW'(1);
					if (st_reg.tidx == st_reg.pcount - PCW'(1)) begin
						st_next.tst    = T_IDLE;
						st_next.pcount = '0;
					end
				end
				default: st_next.tst = T_IDLE;
			endcase
		end
		// Blink phase comes from the refresh timebase itself
		st_next.bcnt  = (st_reg.bcnt == C_BLINK) ? '0 : st_reg.bcnt + 32'h0000_0001;
		st_next.blink = st_reg.blink ^ (st_reg.bcnt == C_BLINK);
		if (selftest_valid) begin
			st_next.selftest = selftest_code;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Buffering and serial output
	dul_fifo #(.WIDTH($bits(dul_pkg::dul_elem_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (st_reg.store[st_reg.didx]),
		.out_valid (elem_valid),
		.out_ready (elem_ready),
		.out_data  (elem)
	);

	dul_link_tx u_tx (
		.clk        (clk),
		.reset      (reset),
		.word_valid (tx_valid),
		.word_ready (tx_ready),
		.word_body  (tx_body),
		.line       (link_tx_line)
	);

	assign elem_visible = (elem.intensity != dul_pkg::INT_BLINK) || st_reg.blink;
	assign pad_codes    = st_reg.pad;
	assign pad_count    = st_reg.pcount;
	assign msg_irq      = st_reg.irq;
	assign msg_error    = st_reg.err;
	assign blink_on     = st_reg.blink;
	assign selftest_status = st_reg.selftest;
	// Last word still on the wire or a fresh command pulse is not idle
	assign quiescent    = st_reg.rx_st == RX_IDLE && st_reg.mstate == M_IDLE
		&& st_reg.tst == T_IDLE && tx_ready && !st_reg.irq && !selftest_fail;

	// ==========================================================
	// Checks
	sequence s_good_cmd;
		st_reg.word_done && w_ok && st_reg.mstate != M_DRAIN
			&& w_cmd.sync == dul_pkg::SYNC_CMD;
	endsequence
	sequence s_enter;
		key_valid && key_code == dul_pkg::KEY_ENTER && st_reg.tst == T_IDLE
			&& st_reg.pcount != '0;
	endsequence
	sequence s_last_data;
		tx_valid && tx_ready && st_reg.tst == T_DATA
			&& st_reg.tidx == st_reg.pcount - PCW'(1);
	endsequence

	property p_irq_match;
		@(posedge clk) disable iff (reset)
		s_good_cmd ##0 (w_cmd.unit_addr == unit_address) |=> msg_irq;
	endproperty
	a_irq_match: assert property (p_irq_match) else $error("irq missing");
	property p_irq_cause;
		@(posedge clk) disable iff (reset)
		msg_irq |-> $past(st_reg.word_done) && $past(w_cmd.unit_addr == unit_address);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
	property p_bad_word;
		@(posedge clk) disable iff (reset)
		st_reg.word_done && !w_ok && st_reg.mstate != M_DRAIN
			|=> msg_error && st_reg.mstate == M_IDLE;
	endproperty
	a_bad_word: assert property (p_bad_word) else $error("bad word kept");
	property p_push_after_word;
		@(posedge clk) disable iff (reset)
		$rose(fifo_in_valid) |-> $past(st_reg.word_done) && $past(w_ok);
	endproperty
	a_push_after_word: assert property (p_push_after_word) else $error("early push");
	property p_echo;
		@(posedge clk) disable iff (reset)
		key_valid && st_reg.tst == T_IDLE && key_code <= dul_pkg::KEY_LAST
			&& key_code != dul_pkg::KEY_ENTER && key_code != dul_pkg::KEY_CLEAR
			&& st_reg.pcount != PCW'(PAD_DEPTH)
			|=> pad_count == $past(pad_count) + PCW'(1);
	endproperty
	a_echo: assert property (p_echo) else $error("key not echoed");
	property p_enter_start;
		@(posedge clk) disable iff (reset)
		s_enter |=> tx_valid && pad_count == $past(pad_count) ##1 !tx_ready;
	endproperty
	a_enter_start: assert property (p_enter_start) else $error("enter mishandled");
	property p_tx_needs_enter;
		@(posedge clk) disable iff (reset)
		$rose(tx_valid) |-> $past(key_valid && key_code == dul_pkg::KEY_ENTER);
	endproperty
	a_tx_needs_enter: assert property (p_tx_needs_enter) else $error("tx w/o enter");
	property p_frame_end;
		@(posedge clk) disable iff (reset)
		s_last_data |=> st_reg.tst == T_IDLE && pad_count == '0;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame end wrong");
	property p_blink;
		@(posedge clk) disable iff (reset)
		$changed(blink_on) |-> $past(st_reg.bcnt) == C_BLINK;
	endproperty
	a_blink: assert property (p_blink) else $error("blink rate wrong");
	property p_quiet;
		@(posedge clk) disable iff (reset)
		quiescent |-> !fifo_in_valid && !tx_valid && !msg_irq && !link_tx_line;
	endproperty
	a_quiet: assert property (p_quiet) else $error("busy while quiet");
endmodule

// ### hdl/dul_pkg.sv
package dul_pkg;
	// ==========================================================
	// Link timing
	localparam int CLK_HZ         = 25000000;
	localparam int LINK_BIT_HZ    = 1000000;
	localparam int BIT_CYC        = CLK_HZ / LINK_BIT_HZ;
	localparam int HALF_CYC       = BIT_CYC / 2;
	localparam int SAMPLE1_CYC    = HALF_CYC / 2;
	localparam int SAMPLE2_CYC    = HALF_CYC + SAMPLE1_CYC;
	localparam int WORD_BITS      = 38;
	localparam int GAP_BITS       = 3;
	localparam int BLINK_HALF_MS  = 250;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	// ==========================================================
	// Word fields and codes
	localparam logic [2:0]  SYNC_CMD        = 3'h5;
	localparam logic [2:0]  SYNC_DATA       = 3'h6;
	localparam logic [10:0] CHECK_POLY      = 11'h385;
	localparam logic [3:0]  MSGC_KEY_DATA   = 4'h1;
	localparam logic [3:0]  MSGC_FORMAT_REQ = 4'h2;
	localparam logic [4:0]  KEY_CRIT_FMT    = 5'h0D;
	localparam logic [4:0]  KEY_OTHER_FMT   = 5'h0E;
	localparam logic [4:0]  KEY_ENTER       = 5'h0F;
	localparam logic [4:0]  KEY_CLEAR       = 5'h13;
	localparam logic [4:0]  KEY_LAST        = 5'h1B;
	localparam logic [1:0]  INT_NORMAL      = 2'h0;
	localparam logic [1:0]  INT_BLINK       = 2'h1;
	localparam logic [1:0]  INT_BRIGHT      = 2'h2;

	// First bit on the wire is the MSB
	typedef struct packed {
		logic [2:0]  sync;
		logic [3:0]  message_control;
		logic [4:0]  unit_addr;
		logic        memory_area_flag;
		logic [8:0]  unit_channel_address;
		logic [4:0]  count;
		logic [10:0] word_check_code;
	} dul_cmd_type;

	typedef struct packed {
		logic [2:0]  sync;
		logic [7:0]  ctrl;
		logic [15:0] payload;
		logic [10:0] word_check_code;
	} dul_data_type;

	typedef struct packed {
		logic        skeleton;
		logic [1:0]  intensity;
		logic [3:0]  code;
		logic [11:0] value;
	} dul_elem_type;

	function automatic logic [10:0] dul_check_code(input logic [26:0] d);
		logic [10:0] c;
		c = '0;
		for (int i = 26; i >= 0; i--) begin
			c = (c[10] ^ d[i]) ? ({c[9:0], 1'b0} ^ CHECK_POLY) : {c[9:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// ### hdl/dul_fifo.sv
`timescale 1ns/1ps
module dul_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input  logic             clk,
	input  logic             reset,
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [WIDTH-1:0] in_data,
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [CW-1:0]               count;
	} dul_fifo_state_type;

	dul_fifo_state_type st_reg;
	dul_fifo_state_type st_next;
	logic               push;
	logic               pop;

	assign in_ready  = st_reg.count != CW'(DEPTH);
	assign out_valid = st_reg.count != '0;
	assign out_data  = st_reg.mem[st_reg.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + AW'(1);
		end
		if (pop) begin
			st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + AW'(1);
		end
		st_next.count = st_reg.count + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// ### hdl/dul_link_tx.sv
`timescale 1ns/1ps
module dul_link_tx (
	input  logic        clk,
	input  logic        reset,
	input  logic        word_valid,
	output logic        word_ready,
	input  logic [26:0] word_body,
	output logic        line
);
	localparam logic [4:0] C_HALF = 5'(dul_pkg::HALF_CYC);
	localparam logic [4:0] C_LAST = 5'(dul_pkg::BIT_CYC - 1);
	localparam logic [5:0] C_WEND = 6'(dul_pkg::WORD_BITS - 1);
	localparam logic [5:0] C_GEND = 6'(dul_pkg::GAP_BITS - 1);

	typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} dul_tx_phase_type;
	typedef struct packed {
		dul_tx_phase_type ph;
		logic [37:0]      sh;
		logic [4:0]       cyc;
		logic [5:0]       bidx;
		logic             line;
	} dul_tx_state_type;

	dul_tx_state_type st_reg;
	dul_tx_state_type st_next;

	assign word_ready = st_reg.ph == TX_IDLE;
	assign line       = st_reg.line;

	always_comb begin
		st_next = st_reg;
		case (st_reg.ph)
			TX_IDLE: begin
				st_next.line = 1'b0;
				if (word_valid) begin
					st_next.sh   = {word_body, dul_pkg::dul_check_code(word_body)};
					st_next.ph   = TX_SEND;
					st_next.cyc  = '0;
					st_next.bidx = '0;
					st_next.line = word_body[26];
				end
			end
			TX_SEND: begin
				// One is high then low; the mid-bit edge carries the clock
				st_next.cyc  = st_reg.cyc + 5'h01;
				st_next.line = st_reg.sh[37] ^ (st_next.cyc >= C_HALF);
				if (st_reg.cyc == C_LAST) begin
					st_next.cyc  = '0;
					st_next.sh   = {st_reg.sh[36:0], 1'b0};
					st_next.bidx = st_reg.bidx + 6'h01;
					st_next.line = st_reg.sh[36];
					if (st_reg.bidx == C_WEND) begin
						st_next.ph   = TX_GAP;
						st_next.bidx = '0;
						st_next.line = 1'b0;
					end
				end
			end
			TX_GAP: begin
				// Low gap lets the far receiver find the next start edge
				st_next.cyc = st_reg.cyc + 5'h01;
				if (st_reg.cyc == C_LAST) begin
					st_next.cyc  = '0;
					st_next.bidx = st_reg.bidx + 6'h01;
					if (st_reg.bidx == C_GEND) begin
						st_next.ph = TX_IDLE;
					end
				end
			end
			default: st_next.ph = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// ### dv/dul_computer_model.sv
`timescale 1ns/1ps
// ==========================================================
// Computer set model: Manchester words in both directions
module dul_computer_model (
	input  logic clk,
	input  logic line_in,
	output logic line_out
);
	logic [37:0] got_q[$];

	function automatic logic [10:0] crc(input logic [26:0] d);
		logic [10:0] c;
		c = '0;
		for (int i = 26; i >= 0; i--) begin
			c = {c[9:0], 1'b0} ^ ((c[10] ^ d[i]) ? dul_pkg::CHECK_POLY : 11'h000);
		end
		return c;
	endfunction

	// Called at a falling edge; bad flips the low bit of the check code on purpose
	task automatic send(input logic [26:0] body, input logic bad);
		logic [37:0] w;
		w = {body, crc(body) ^ {10'h000, bad}};
		for (int i = 37; i >= 0; i--) begin
			line_out = w[i];
			repeat (12) @(negedge clk);
			line_out = ~w[i];
			repeat (13) @(negedge clk);
		end
		line_out = 1'b0;
		repeat (75) @(negedge clk);
	endtask

	initial line_out = 1'b0;

	// Both sync codes start with a one, so a rise marks a word start
	initial begin
		logic [37:0] w;
		forever begin
			do begin
				@(posedge clk);
			end while (line_in !== 1'b1);
			repeat (5) @(posedge clk);
			for (int i = 37; i >= 0; i--) begin
				w[i] = line_in;
				if (i > 0) repeat (25) @(posedge clk);
			end
			got_q.push_back(w);
			repeat (40) @(posedge clk);
		end
	end
endmodule

// ### dv/test_dul_display_link.sv
`timescale 1ns/1ps
module test_dul_display_link;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  link_rx_line;
	logic                  link_tx_line;
	logic [4:0]            ua = 5'h0B;
	logic                  key_valid = 1'b0;
	logic [4:0]            key_code = 5'h00;
	logic                  selftest_valid = 1'b0;
	logic [7:0]            selftest_code = 8'h00;
	logic                  selftest_fail = 1'b0;
	logic                  elem_valid;
	logic                  elem_ready = 1'b0;
	dul_pkg::dul_elem_type elem;
	logic                  elem_visible;
	logic [39:0]           pad_codes;
	logic [3:0]            pad_count;
	logic                  msg_irq;
	logic                  msg_error;
	logic                  blink_on;
	logic                  quiescent;
	logic [7:0]            selftest_status;
	int                    errors = 0;
	int                    total_checks = 0;
	int                    cycles = 0;
	int                    n_irq = 0;
	int                    n_err = 0;
	logic [18:0]           elem_q[$];
	logic [26:0]           b;
	logic                  ph;

	always #20 clk = ~clk;

	dul_display_link #(.BLINK_HALF_CYC(16)) i_dul_display_link (
		.clk(clk), .reset(reset), .link_rx_line(link_rx_line), .link_tx_line(link_tx_line),
		.unit_address(ua), .key_valid(key_valid), .key_code(key_code),
		.selftest_valid(selftest_valid), .selftest_code(selftest_code),
		.selftest_fail(selftest_fail),
		.elem_valid(elem_valid), .elem_ready(elem_ready), .elem(elem),
		.elem_visible(elem_visible), .pad_codes(pad_codes), .pad_count(pad_count),
		.msg_irq(msg_irq), .msg_error(msg_error), .blink_on(blink_on),
		.quiescent(quiescent), .selftest_status(selftest_status)
	);

	dul_computer_model i_dul_computer_model (
		.clk(clk), .line_in(link_tx_line), .line_out(link_rx_line)
	);

	always @(posedge clk) begin
		cycles++;
		if (msg_irq === 1'b1) n_irq++;
		if (msg_error === 1'b1) n_err++;
		if (elem_valid === 1'b1 && elem_ready === 1'b1) elem_q.push_back(elem);
		// Whole run needs about 9300 cycles
		if (cycles == 30000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic key(input logic [4:0] c);
		@(negedge clk);
		key_valid = 1'b1;
		key_code = c;
		@(negedge clk);
		key_valid = 1'b0;
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		check(quiescent, 1'b1);
		check(pad_count, 4'h0);
		selftest_valid = 1'b1;
		selftest_code = 8'hA5;
		@(negedge clk);
		selftest_valid = 1'b0;
		selftest_fail = 1'b1;
		@(negedge clk);
		check(selftest_status, 8'hA5);
		check(quiescent, 1'b0);
		selftest_fail = 1'b0;
		key(5'h03);
		key(5'h05);
		key(5'h1C);
		check(pad_count, 4'h2);
		check(pad_codes[9:0], {5'h05, 5'h03});
		key(dul_pkg::KEY_CLEAR);
		check(pad_count, 4'h0);
		key(dul_pkg::KEY_ENTER);
		key(dul_pkg::KEY_CRIT_FMT);
		key(5'h07);
		repeat (60) @(negedge clk);
		check(pad_count, 4'h2);
		check(i_dul_computer_model.got_q.size(), 0);
		key(dul_pkg::KEY_ENTER);
		for (int i = 0; i < 4000 && i_dul_computer_model.got_q.size() < 3; i++) @(negedge clk);
		// Last data word is still being shifted out here
		check(quiescent, 1'b0);
		b = {3'h5, 4'h2, ua, 1'b0, 9'h000, 5'd2};
		check(i_dul_computer_model.got_q[0], {b, i_dul_computer_model.crc(b)});
		b = {3'h6, 8'h00, 11'h000, 5'h0D};
		check(i_dul_computer_model.got_q[1], {b, i_dul_computer_model.crc(b)});
		b = {3'h6, 8'h00, 11'h000, 5'h07};
		check(i_dul_computer_model.got_q[2], {b, i_dul_computer_model.crc(b)});
		check(pad_count, 4'h0);
		// Skeleton word with blink and bright elements, consumer stalled
		i_dul_computer_model.send({3'h5, 4'h1, ua, 1'b1, 9'h000, 5'd2}, 1'b0);
		i_dul_computer_model.send({3'h6, 8'h01, 16'h1234}, 1'b0);
		i_dul_computer_model.send({3'h6, 8'h02, 16'h5ABC}, 1'b0);
		check(n_irq, 1);
		check(elem_valid, 1'b1);
		while (blink_on !== 1'b0) @(negedge clk);
		check(elem_visible, 1'b0);
		while (blink_on !== 1'b1) @(negedge clk);
		check(elem_visible, 1'b1);
		check(elem_q.size(), 0);
		elem_ready = 1'b1;
		repeat (5) @(negedge clk);
		check(elem_q.size(), 2);
		check(elem_q[0], {1'b1, 2'h1, 4'h1, 12'h234});
		check(elem_q[1], {1'b1, 2'h2, 4'h5, 12'hABC});
		i_dul_computer_model.send({3'h5, 4'h1, ua ^ 5'h01, 1'b0, 9'h000, 5'd0}, 1'b0);
		check(n_irq, 1);
		check(n_err, 0);
		i_dul_computer_model.send({3'h5, 4'h1, ua, 1'b0, 9'h000, 5'd0}, 1'b1);
		check(n_err, 1);
		check(n_irq, 1);
		i_dul_computer_model.send({3'h5, 4'h1, ua, 1'b0, 9'h000, 5'd0}, 1'b0);
		check(n_irq, 2);
		check(n_err, 1);
		ph = blink_on;
		repeat (16) @(negedge clk);
		check(blink_on, !ph);
		check(quiescent, 1'b1);
		wrap_up();
	end
endmodule
